// File: rtl/trs_cfg.svh
`ifndef TRS_CFG_SVH
`define TRS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TRS_CLK_NS 100
`define TRS_REL_NS 250000
// Slightly more than the release time: round up, then one cycle extra
`define TRS_REL_CYC ((`TRS_REL_NS + `TRS_CLK_NS - 1) / `TRS_CLK_NS + 1)
`define TRS_POR_CYC_DEF 10000

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TRS_OFF_CTRL 4'h0
`define TRS_OFF_CMD 4'h4
`define TRS_OFF_STAT 4'h8
`define TRS_OFF_MASK 4'hc

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TRS_CTRL_SENS 0
`define TRS_CTRL_PMODE 1
`define TRS_CTRL_SLEEP 2
`define TRS_CTRL_GAIN_LO 4
`define TRS_CMD_SOFT 0
`define TRS_ST_TXRDY 0
`define TRS_ST_RXTH 1
`define TRS_ST_OVF 2
`define TRS_ST_EXT 3
`define TRS_ST_WAKE 4
`define TRS_ST_LOWV 5
`define TRS_ST_POR 6
`define TRS_ST_INRST 8
`define TRS_ST_PIN 9
`define TRS_NEV 7
`define TRS_MASK_RST 7'h7f
`define TRS_STAT_RST 7'h40

`endif

// File: rtl/trs_pkg.sv
package trs_pkg;
    // Reset sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_POR = 4'b0001,
        ST_HELD = 4'b0010,
        ST_REL = 4'b0100,
        ST_RUN = 4'b1000
    } trs_state_t;

    // Input amplifier gain steps, 0 dB down to -20 dB
    typedef enum logic [1:0] {
        GAIN_MAX = 2'h0,
        GAIN_STEP1 = 2'h1,
        GAIN_STEP2 = 2'h2,
        GAIN_MIN = 2'h3
    } trs_gain_t;
endpackage

// File: rtl/trs_sync_if.sv
`timescale 1ns/1ns
// Raw pin levels in, filtered levels out
interface trs_sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: rtl/trs_pin_sync.sv
`timescale 1ns/1ns
module trs_pin_sync
    import trs_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin levels
    trs_sync_if.sync sif
);
    logic [W-1:0] s1_reg; // First stage, read only by s2
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // A change counts only once stages two and three agree, bit by bit,
    // so one pin still settling never holds back the others
    assign out_next = ((s2_reg ^ s3_reg) & out_reg) | (~(s2_reg ^ s3_reg) & s3_reg);

    // ----------------------------------------
    // Three-flop chain
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg <= sif.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sif.clean = out_reg;
endmodule

// File: rtl/trs_top.sv
`timescale 1ns/1ns
`include "trs_cfg.svh"

// Summary of operation
// - Reset pin held low keeps device reset
// - Stay reset slightly over 0.25 ms after release
// - Open-drain pin pulled low during power-on
// - Commands refused while any reset runs
// - Power-on, glitch, software, pin all reset
// - Software command gives short 0.25 ms reset
// - Software reset only in sensitive mode
// - Low external interrupt raises host interrupt
// - Cause sits in status low seven bits
// - External interrupt low wakes from sleep
// - Pin alternatively outputs data-valid indicator
// - Four gain steps, 0 to -20 dB
// - Active-low interrupt on seven event kinds
module trs_top
    import trs_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `TRS_POR_CYC_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Open-drain reset pin
    input wire logic rst_pin_n_in,
    output logic rst_pin_n_out,
    output logic rst_pin_n_oe,
    // Dual-purpose interrupt / data-valid pin
    input wire logic ext_irq_or_valid_pin_in,
    output logic ext_irq_or_valid_pin_out,
    output logic ext_irq_or_valid_pin_oe,
    // Analog supply glitch detector, asynchronous
    input wire logic supply_glitch,
    // Internal event pulses, same clock
    input wire logic tx_buf_ready,
    input wire logic rx_threshold,
    input wire logic fifo_ovf_unf,
    input wire logic wake_timeout,
    input wire logic low_supply,
    input wire logic data_valid_indicator,
    // Interrupts
    output logic host_irq_line_n,
    output logic irq,
    // Device state
    output logic device_in_reset,
    output logic sleep_active,
    output trs_gain_t input_amplifier_gain
);
    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [13:0] REL_CNT = 14'(`TRS_REL_CYC - 1);
    localparam logic [13:0] POR_CNT = 14'(POR_CYCLES - 1);
    localparam int NEV = `TRS_NEV;

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    trs_sync_if #(.W(3)) sif ();
    logic rst_pin_s; // Filtered reset pin level
    logic int_pin_s; // Filtered dual pin level
    logic glitch_s; // Filtered glitch flag

    assign sif.raw = {supply_glitch, ext_irq_or_valid_pin_in, rst_pin_n_in};

    // Idle levels: pins high, glitch clear
    trs_pin_sync #(.W(3), .INIT(3'h3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif)
    );

    assign rst_pin_s = sif.clean[0];
    assign int_pin_s = sif.clean[1];
    assign glitch_s = sif.clean[2];

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    trs_state_t state_reg; // Reset sequencer
    trs_state_t state_next;
    logic [13:0] cnt_reg; // Release and power-on counter
    logic [13:0] cnt_next;
    logic sens_reg; // Sensitive reset mode
    logic pmode_reg; // 1: pin is data-valid output
    logic sleep_reg; // Sleep requested
    trs_gain_t gain_reg; // Amplifier step
    logic [NEV-1:0] stat_reg; // Sticky causes
    logic [NEV-1:0] stat_next;
    logic [NEV-1:0] mask_reg; // Interrupt enables
    logic int_prev_reg; // For falling edge of dual pin

    // AXI state
    logic aw_full_reg;
    logic [3:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Decide whether an offset names a register
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == `TRS_OFF_CTRL) || (a == `TRS_OFF_CMD) ||
                    (a == `TRS_OFF_STAT) || (a == `TRS_OFF_MASK);
    endfunction

    wire in_reset = (state_reg != ST_RUN);
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
    // Writes during any reset are dropped and answered SLVERR
    wire wr_ok = wr_go & is_mapped(aw_addr_reg) & ~in_reset;
    wire wr_ctrl = wr_ok & (aw_addr_reg == `TRS_OFF_CTRL) & w_strb_reg[0];
    wire wr_cmd = wr_ok & (aw_addr_reg == `TRS_OFF_CMD) & w_strb_reg[0];
    wire wr_mask = wr_ok & (aw_addr_reg == `TRS_OFF_MASK) & w_strb_reg[0];
    // Software reset honoured only in sensitive mode
    wire soft_req = wr_cmd & w_data_reg[`TRS_CMD_SOFT] & sens_reg;
    wire rd_stat = ar_hs & (s_axi_araddr == `TRS_OFF_STAT);

    // ----------------------------------------
    // Events
    // ----------------------------------------
    // Dual pin as interrupt input only when not the data-valid output
    wire int_mode = ~pmode_reg;
    wire ext_fall = int_mode & int_prev_reg & ~int_pin_s;
    wire wake_req = int_mode & ~int_pin_s & sleep_reg;
    wire por_done = (state_reg == ST_POR) & (cnt_reg == POR_CNT);
    wire [NEV-1:0] ev_set = {
        por_done,
        low_supply,
        wake_timeout,
        ext_fall,
        fifo_ovf_unf,
        rx_threshold,
        tx_buf_ready
    };
    // Read clears; a simultaneous event survives the clear
    assign stat_next = (stat_reg & ~({NEV{rd_stat}})) | ev_set;
    wire irq_any = |(stat_reg & mask_reg);

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    // Any hard source (pin low or glitch) parks the device in HELD
    wire hard_src = ~rst_pin_s | glitch_s;
    wire rel_done = (cnt_reg == REL_CNT);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 14'h1;
        unique case (state_reg)
            ST_POR: begin
                // Pin pulled low by us for the whole power-on time
                if (por_done) begin
                    state_next = ST_HELD;
                end
            end
            ST_HELD: begin
                // Wait for the pin to rise and the supply to settle
                cnt_next = 14'h0;
                if (!hard_src) begin
                    state_next = ST_REL;
                end
            end
            ST_REL: begin
                if (hard_src) begin
                    state_next = ST_HELD;
                    cnt_next = 14'h0;
                end else if (rel_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_next = 14'h0;
                if (hard_src) begin
                    state_next = ST_HELD;
                end else if (soft_req) begin
                    state_next = ST_REL;
                end
            end
        endcase
    end

    // Sequencer flops; aresetn stands for power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_POR;
            cnt_reg <= 14'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Device reset returns configuration to defaults
    always_ff @(posedge aclk) begin
        if (!aresetn || in_reset) begin
            sens_reg <= 1'b0;
            pmode_reg <= 1'b0;
            sleep_reg <= 1'b0;
            gain_reg <= GAIN_MAX;
            mask_reg <= `TRS_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                sens_reg <= w_data_reg[`TRS_CTRL_SENS];
                pmode_reg <= w_data_reg[`TRS_CTRL_PMODE];
                gain_reg <= trs_gain_t'(w_data_reg[`TRS_CTRL_GAIN_LO +: 2]);
            end
            // Wake wins over a write that would keep sleeping
            if (wake_req) begin
                sleep_reg <= 1'b0;
            end else if (wr_ctrl) begin
                sleep_reg <= w_data_reg[`TRS_CTRL_SLEEP];
            end
            if (wr_mask) begin
                mask_reg <= w_data_reg[NEV-1:0];
            end
        end
    end

    // Status survives device reset so the cause can be read later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= `TRS_STAT_RST;
            int_prev_reg <= 1'b1;
        end else begin
            stat_reg <= stat_next;
            int_prev_reg <= int_pin_s;
        end
    end

    // ----------------------------------------
    // Pin and status outputs
    // ----------------------------------------
    // All outputs but the tied-low rst_pin_n_out registered to keep pins glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_n_oe <= 1'b1;
            ext_irq_or_valid_pin_out <= 1'b0;
            ext_irq_or_valid_pin_oe <= 1'b0;
            host_irq_line_n <= 1'b1;
            irq <= 1'b0;
            device_in_reset <= 1'b1;
            sleep_active <= 1'b0;
            input_amplifier_gain <= GAIN_MAX;
        end else begin
            rst_pin_n_oe <= (state_next == ST_POR);
            ext_irq_or_valid_pin_out <= data_valid_indicator;
            ext_irq_or_valid_pin_oe <= pmode_reg & ~in_reset;
            host_irq_line_n <= ~irq_any;
            irq <= irq_any;
            device_in_reset <= (state_next != ST_RUN);
            sleep_active <= sleep_reg;
            input_amplifier_gain <= gain_reg;
        end
    end

    // Open drain: only ever drives low
    assign rst_pin_n_out = 1'b0;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data taken in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else begin
            if (aw_hs) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (w_hs) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    // Read data mux
    wire [31:0] stat_word = {22'h0, int_pin_s, in_reset, 1'b0, stat_reg};
    wire [31:0] ctrl_word = {26'h0, gain_reg, 1'b0, sleep_reg, pmode_reg, sens_reg};
    wire [31:0] rd_mux =
        (s_axi_araddr == `TRS_OFF_CTRL) ? ctrl_word :
        (s_axi_araddr == `TRS_OFF_STAT) ? stat_word :
        (s_axi_araddr == `TRS_OFF_MASK) ? {25'h0, mask_reg} : 32'h0;

    // One read in flight; arready drops until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        end else if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end else begin
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

// File: verif/trs_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host side of the reset and dual pins
// ----------------------------------------
module trs_host (
    // Host controls set by the bench
    input wire logic hold_rst,
    input wire logic int_lvl,
    // Device pin drivers
    input wire logic rst_pin_n_oe,
    input wire logic rst_pin_n_out,
    input wire logic ext_irq_or_valid_pin_oe,
    input wire logic ext_irq_or_valid_pin_out,
    // Resolved wire levels
    output logic rst_pin_n_in,
    output logic ext_irq_or_valid_pin_in
);
    // Open drain with weak pull-up: any low driver wins
    assign rst_pin_n_in = !hold_rst && !(rst_pin_n_oe && !rst_pin_n_out);
    // Host drives the pin only while the device does not
    assign ext_irq_or_valid_pin_in = ext_irq_or_valid_pin_oe ? ext_irq_or_valid_pin_out : int_lvl;
endmodule

// File: verif/trs_top_checker.sv
`timescale 1ns/1ns
module trs_chk #(
    parameter int unsigned POR_CYCLES = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channel handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    // Pins
    input wire logic rst_pin_n_in,
    input wire logic rst_pin_n_out,
    input wire logic rst_pin_n_oe,
    input wire logic ext_irq_or_valid_pin_in,
    input wire logic ext_irq_or_valid_pin_out,
    input wire logic ext_irq_or_valid_pin_oe,
    input wire logic supply_glitch,
    input wire logic data_valid_indicator,
    // Device state
    input wire logic host_irq_line_n,
    input wire logic irq,
    input wire logic device_in_reset,
    input wire logic sleep_active
);
    // Saturating counts: pin high, and time spent in reset
    logic [11:0] hi_cnt;
    logic [11:0] in_cnt;
    always_ff @(posedge aclk) begin
        hi_cnt <= (!aresetn || !rst_pin_n_in || supply_glitch) ? 12'h0 :
            hi_cnt + 12'(hi_cnt != 12'hfff);
        in_cnt <= (!aresetn || !device_in_reset) ? 12'h0 : in_cnt + 12'(in_cnt != 12'hfff);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pin_holds_reset: assert property (!rst_pin_n_in [*6] |-> device_in_reset)
        else $error("reset pin low yet device running");
    a_release_time: assert property ($fell(device_in_reset) |-> hi_cnt >= 12'h9c5)
        else $error("left reset too soon after pin release");
    a_por_pulls_pin: assert property ($rose(aresetn) |-> (rst_pin_n_oe && !rst_pin_n_out) [*8])
        else $error("pin not pulled low during power-on");
    a_cmd_refused: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && device_in_reset ##1 device_in_reset |=> s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("write during reset not refused");
    a_glitch_reset: assert property (supply_glitch [*6] |-> device_in_reset)
        else $error("glitch did not reset device");
    a_reset_length: assert property ($fell(device_in_reset) |-> in_cnt >= 12'h9c5)
        else $error("reset period too short");
    a_irq_polarity: assert property (host_irq_line_n != irq)
        else $error("interrupt line not inverse of irq");
    a_valid_copy: assert property (ext_irq_or_valid_pin_oe && $past(ext_irq_or_valid_pin_oe)
        |-> ext_irq_or_valid_pin_out == $past(data_valid_indicator))
        else $error("data valid output wrong");
    a_oe_off_reset: assert property (device_in_reset && $past(device_in_reset)
        |-> !ext_irq_or_valid_pin_oe)
        else $error("dual pin driven during reset");
    a_wake_on_low: assert property ((!ext_irq_or_valid_pin_oe && !ext_irq_or_valid_pin_in) [*8]
        |-> !sleep_active)
        else $error("low interrupt input did not wake");
endmodule
bind trs_top trs_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);

// File: verif/trs_top_tb.sv
`timescale 1ns/1ns
module trs_top_tb
    import trs_pkg::*;
;
    // ----------------------------------------
    // Signals, inputs start idle
    // ----------------------------------------
    logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, hold_rst = 1'b0, int_lvl = 1'b1;
    logic supply_glitch = 1'b0, data_valid_indicator = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, m;
    logic [4:0] ev = 5'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic rst_pin_n_in, rst_pin_n_out, rst_pin_n_oe, host_irq_line_n, irq, device_in_reset;
    logic ext_irq_or_valid_pin_in, ext_irq_or_valid_pin_out, ext_irq_or_valid_pin_oe;
    logic tx_buf_ready, rx_threshold, fifo_ovf_unf, wake_timeout, low_supply, sleep_active;
    trs_gain_t input_amplifier_gain;
    int err_count = 0, n_compared = 0, seed = 3, i, n, c, k, e;
    // Event pulses share one vector for random picks
    assign {low_supply, wake_timeout, fifo_ovf_unf, rx_threshold, tx_buf_ready} = ev;
    // Short power-on count keeps the run brief
    trs_top #(.POR_CYCLES(20)) u_trs_top (.*);
    trs_host u_trs_host (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        if (n == 50) begin
            err_count++;
            results();
        end
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) begin
            err_count++;
            results();
        end
    endtask
    // Bounded wait for the device to leave reset
    task automatic run_wait();
        for (c = 0; c < 4000 && device_in_reset !== 1'b0; c++) @(posedge aclk);
        if (c == 4000) begin
            err_count++;
            results();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(rst_pin_n_oe), 32'h1);
        rd(4'h8);
        chk(d & 32'h140, 32'h140);
        chk(32'(r), 32'h0);
        chk(32'(host_irq_line_n), 32'h0);
        wr(4'h0, 32'h30);
        chk(32'(r), 32'h2);
        run_wait();
        chk(32'(input_amplifier_gain), 32'h0);
        rd(4'hc);
        chk(d, 32'h7f);
        // Every gain step, checked at the amplifier gain output
        for (i = 0; i < 4; i++) begin
            wr(4'h0, 32'(i) << 4);
            repeat (2) @(posedge aclk);
            chk(32'(input_amplifier_gain), 32'(i));
        end
        // Random events under random masks, first mask empty
        for (i = 0; i < 20; i++) begin
            m = (i == 0) ? 32'h0 : $random(seed) & 32'h7f;
            wr(4'hc, m);
            rd(4'h8);
            k = {$random(seed)} % 5;
            e = (k < 3) ? k : k + 1;
            ev <= 5'h1 << k;
            @(posedge aclk);
            ev <= 5'h0;
            repeat (3) @(posedge aclk);
            chk(32'(irq), 32'(m[e]));
            rd(4'h8);
            chk(d & 32'h7f, 32'h1 << e);
        end
        // External interrupt wakes a sleeping device
        wr(4'hc, 32'h7f);
        wr(4'h0, 32'h4);
        @(posedge aclk);
        chk(32'(sleep_active), 32'h1);
        int_lvl <= 1'b0;
        repeat (8) @(posedge aclk);
        int_lvl <= 1'b1;
        chk(32'(sleep_active), 32'h0);
        chk(32'(host_irq_line_n), 32'h0);
        rd(4'h8);
        chk(d & 32'hf, 32'h8);
        // Pin turned round to a data valid output
        wr(4'h0, 32'h2);
        // Pin output lags the indicator by one cycle
        e = 0;
        for (i = 0; i < 8; i++) begin
            k = $random(seed) & 1;
            data_valid_indicator <= 1'(k);
            @(posedge aclk);
            chk(32'(ext_irq_or_valid_pin_oe), 32'h1);
            chk(32'(ext_irq_or_valid_pin_out), 32'(e));
            e = k;
        end
        // Soft reset ignored, then honoured in sensitive mode
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h1);
        repeat (3) @(posedge aclk);
        chk(32'(device_in_reset), 32'h0);
        wr(4'h0, 32'h1);
        wr(4'h4, 32'h1);
        repeat (2) @(posedge aclk);
        rd(4'h0);
        chk(d, 32'h0);
        run_wait();
        chk(32'(c > 2490 && c < 2510), 32'h1);
        // Pin held low, then a supply glitch
        for (i = 0; i < 2; i++) begin
            {supply_glitch, hold_rst} <= 2'h1 << i;
            repeat (10) @(posedge aclk);
            chk(32'(device_in_reset), 32'h1);
            {supply_glitch, hold_rst} <= 2'h0;
            run_wait();
            chk(32'(c > 2500), 32'h1);
        end
        // Second power-on in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(32'({rst_pin_n_oe, rst_pin_n_in}), 32'h2);
        results();
    end
endmodule
